// >>> rxs_map.svh
/*
 * Constants for the reset and exception-entry sequencer.
 * Assumes inclusion by bare name from the design files and the bench.
 */
`ifndef RXS_MAP_SVH
`define RXS_MAP_SVH

`define RXS_RESET_VECTOR    16'h0000
`define RXS_VEC_LO_ADDR     16'h0000
`define RXS_VEC_HI_ADDR     16'h0001
`define RXS_MIN_LOW_CYCLES  4'ha
`define RXS_WDT_MAX         8'hff
`define RXS_WDT_ZERO        8'h00
`define RXS_INIT_HOLD       2'h2

`endif

// >>> rxs_pkg.sv
/*
 * Types for the reset and exception-entry sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rxs_pkg;
    typedef enum logic [2:0] {
        RXS_ST_RESET,
        RXS_ST_INIT,
        RXS_ST_VEC_LO,
        RXS_ST_VEC_HI,
        RXS_ST_FIRST,
        RXS_ST_RUN,
        RXS_ST_IRQ
    } rxs_state_t;
endpackage : rxs_pkg

// >>> rxs_wdt_if.sv
/*
 * Interface between the sequencer and its watchdog.
 * Assumes a single clock domain.
 */
interface rxs_wdt_if;
    logic run_enable;
    logic overflow;
    logic reset_flag;
    logic clear_flag;
    modport wdt (input run_enable, input clear_flag, output overflow, output reset_flag);
    modport seq (output run_enable, output clear_flag, input overflow, input reset_flag);
endinterface : rxs_wdt_if

// >>> rxs_watchdog.sv
/*
 * Watchdog counter with reset flag.
 * Assumes clk at 40 MHz, async active-high sys_rst, clock enable.
 */
`include "rxs_map.svh"
module rxs_watchdog
    import rxs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Sequencer side
    rxs_wdt_if.wdt    wdt
);
    logic [7:0] watchdog_count_r;
    logic [7:0] watchdog_count_nxt;
    logic       watchdog_reset_flag_r;
    logic       watchdog_reset_flag_nxt;
    logic       ovf;

    assign ovf = wdt.run_enable && (watchdog_count_r == `RXS_WDT_MAX);

    always_comb begin
        watchdog_count_nxt      = watchdog_count_r;
        watchdog_reset_flag_nxt = watchdog_reset_flag_r;
        if (wdt.run_enable) begin
            watchdog_count_nxt = watchdog_count_r + 8'h01; // [RQ9]
        end
        if (wdt.clear_flag) begin
            watchdog_reset_flag_nxt = 1'b0;
        end
        if (ovf) begin
            watchdog_reset_flag_nxt = ~watchdog_reset_flag_r; // [RQ10] [RQ11]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_count_r      <= `RXS_WDT_ZERO;
            watchdog_reset_flag_r <= 1'b0;
        end else if (clk_en) begin
            watchdog_count_r      <= watchdog_count_nxt;
            watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
        end
    end

    assign wdt.overflow   = ovf;
    assign wdt.reset_flag = watchdog_reset_flag_r;

    AST_WDT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && !wdt.run_enable) |=> $stable(watchdog_count_r)) // [RQ9]
        else $error("Watchdog counted while disabled");
endmodule : rxs_watchdog

// >>> rxs_sequencer.sv
/*
 * Reset and exception-entry sequencer: pin and watchdog reset,
 * vector fetch, first-instruction interrupt block, interrupt entry.
 * Assumes synchronous inputs, clk 40 MHz, async active-high sys_rst,
 * a CPU that reports instruction boundaries and a memory read port.
 */
`include "rxs_map.svh"
// What this block does
// RQ1: Pending reset always wins over any interrupt request.
// RQ2: Interrupt entry starts only at an instruction or exception boundary.
// RQ3: Low reset pin halts everything at once and holds reset state.
// RQ4: Outside source holds reset pin low at least ten clocks.
// RQ5: At power-up source holds reset low until clock stable.
// RQ6: Reset pin returning high starts reset exception handling.
// RQ7: Reset handling initializes CPU and peripherals, sets interrupt mask.
// RQ8: Program counter loads from vector word 0000-0001, then fetch starts.
// RQ9: Watchdog counts only while its run-enable bit is one.
// RQ10: First watchdog overflow sets reset flag and enters reset state.
// RQ11: Overflow with flag set ends reset and starts reset handling.
// RQ12: All interrupts, even non-maskable, blocked until first instruction ran.
// RQ13: Mask bit set refuses all interrupts except the non-maskable one.
module rxs_sequencer
    import rxs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Board reset pin, active low
    input  wire logic        external_reset_input_n,
    // Watchdog control
    input  wire logic        watchdog_run_enable,
    // CPU status
    input  wire logic        insn_boundary,
    input  wire logic        irq_req,
    input  wire logic        nmi_req,
    input  wire logic        cpu_mask_clear,
    // Vector memory read
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    // Control outputs
    output logic             halt,
    output logic             periph_init,
    output logic             cpu_start,
    output logic      [15:0] pc_load,
    output logic             irq_mask_bit,
    output logic             irq_take,
    output logic             nmi_take,
    output logic             watchdog_reset_flag
);
    rxs_wdt_if wif ();

    rxs_watchdog u_wdt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .wdt     (wif.wdt)
    );

    rxs_state_t  state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic        mask_r, mask_nxt;
    logic [1:0]  hold_r, hold_nxt;
    logic        wdt_rst_r, wdt_rst_nxt;
    logic        irq_take_nxt, nmi_take_nxt;
    logic        irq_take_r, nmi_take_r;
    logic        pin_low;

    assign pin_low            = !external_reset_input_n;
    assign wif.run_enable     = watchdog_run_enable && !pin_low; // [RQ9]
    // Pin reset reinitialises the watchdog flag so a later overflow resets again
    assign wif.clear_flag     = pin_low; // [RQ7]

    always_comb begin
        state_nxt    = state_r;
        pc_nxt       = pc_r;
        mask_nxt     = mask_r;
        hold_nxt     = hold_r;
        wdt_rst_nxt  = wdt_rst_r;
        irq_take_nxt = 1'b0;
        nmi_take_nxt = 1'b0;
        if (pin_low) begin
            state_nxt   = RXS_ST_RESET; // [RQ3] [RQ1]
            wdt_rst_nxt = 1'b0;
            mask_nxt    = 1'b1;
        end else if (wif.overflow && !wif.reset_flag) begin
            state_nxt   = RXS_ST_RESET; // [RQ10] [RQ1]
            wdt_rst_nxt = 1'b1;
            mask_nxt    = 1'b1;
        end else begin
            case (state_r)
                RXS_ST_RESET: begin
                    if (!wdt_rst_r || (wif.overflow && wif.reset_flag)) begin
                        state_nxt   = RXS_ST_INIT; // [RQ6] [RQ11]
                        wdt_rst_nxt = 1'b0;
                        hold_nxt    = `RXS_INIT_HOLD;
                    end
                end
                RXS_ST_INIT: begin
                    mask_nxt = 1'b1; // [RQ7]
                    hold_nxt = hold_r - 2'h1;
                    if (hold_r == 2'h0) begin
                        state_nxt = RXS_ST_VEC_LO;
                    end
                end
                RXS_ST_VEC_LO: begin
                    pc_nxt    = {mem_rdata, pc_r[7:0]}; // [RQ8]
                    state_nxt = RXS_ST_VEC_HI;
                end
                RXS_ST_VEC_HI: begin
                    pc_nxt    = {pc_r[15:8], mem_rdata}; // [RQ8]
                    state_nxt = RXS_ST_FIRST;
                end
                RXS_ST_FIRST: begin
                    if (cpu_mask_clear) begin
                        mask_nxt = 1'b0;
                    end
                    if (insn_boundary) begin
                        state_nxt = RXS_ST_RUN; // [RQ12]
                    end
                end
                RXS_ST_RUN: begin
                    if (cpu_mask_clear) begin
                        mask_nxt = 1'b0;
                    end
                    if (insn_boundary && nmi_req) begin
                        nmi_take_nxt = 1'b1; // [RQ2] [RQ13]
                        mask_nxt     = 1'b1;
                        state_nxt    = RXS_ST_IRQ;
                    end else if (insn_boundary && irq_req && !mask_r) begin
                        irq_take_nxt = 1'b1; // [RQ2] [RQ13]
                        mask_nxt     = 1'b1;
                        state_nxt    = RXS_ST_IRQ;
                    end
                end
                RXS_ST_IRQ: begin
                    if (insn_boundary) begin
                        state_nxt = RXS_ST_RUN; // [RQ2]
                    end
                end
                default: state_nxt = RXS_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= RXS_ST_RESET;
            pc_r       <= `RXS_RESET_VECTOR;
            mask_r     <= 1'b1;
            hold_r     <= 2'h0;
            wdt_rst_r  <= 1'b0;
            irq_take_r <= 1'b0;
            nmi_take_r <= 1'b0;
        end else if (clk_en) begin
            state_r    <= state_nxt;
            pc_r       <= pc_nxt;
            mask_r     <= mask_nxt;
            hold_r     <= hold_nxt;
            wdt_rst_r  <= wdt_rst_nxt;
            irq_take_r <= irq_take_nxt;
            nmi_take_r <= nmi_take_nxt;
        end
    end

    // Halt is immediate on the pin, not registered
    assign halt                = pin_low || (state_r == RXS_ST_RESET); // [RQ3]
    assign periph_init         = (state_r == RXS_ST_RESET) || (state_r == RXS_ST_INIT); // [RQ7]
    assign mem_rd              = (state_r == RXS_ST_VEC_LO) || (state_r == RXS_ST_VEC_HI);
    assign mem_addr            = (state_r == RXS_ST_VEC_HI) ? `RXS_VEC_HI_ADDR : `RXS_VEC_LO_ADDR;
    assign cpu_start           = (state_r == RXS_ST_FIRST) || (state_r == RXS_ST_RUN)
                                 || (state_r == RXS_ST_IRQ);
    assign pc_load             = pc_r;
    assign irq_mask_bit        = mask_r;
    assign irq_take            = irq_take_r;
    assign nmi_take            = nmi_take_r;
    assign watchdog_reset_flag = wif.reset_flag;

    AST_PIN_HALT: assert property (@(posedge clk) disable iff (sys_rst)
        pin_low |-> halt) // [RQ3]
        else $error("Not halted while reset pin low");
    AST_PIN_STATE: assert property (@(posedge clk) disable iff (sys_rst)
        (pin_low && clk_en) |=> state_r == RXS_ST_RESET) // [RQ3]
        else $error("Reset state not entered");
    AST_RELEASE_INIT: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && !pin_low && state_r == RXS_ST_RESET && !wdt_rst_r && !wif.overflow)
        |=> state_r == RXS_ST_INIT) // [RQ6]
        else $error("Release did not start handling");
    AST_MASK_INIT: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == RXS_ST_VEC_LO) |-> mask_r) // [RQ7]
        else $error("Mask not set during reset handling");
    AST_VEC_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == RXS_ST_VEC_LO) |-> mem_rd && mem_addr == `RXS_VEC_LO_ADDR) // [RQ8]
        else $error("Wrong vector address");
    AST_FIRST_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == RXS_ST_FIRST && clk_en) |=> !irq_take_r && !nmi_take_r) // [RQ12]
        else $error("Interrupt taken before first instruction");
    AST_MASKED: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(irq_take_r) |-> !$past(mask_r) && $past(insn_boundary)) // [RQ13] [RQ2]
        else $error("Masked interrupt accepted");
    AST_RESET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && pin_low) |=> !irq_take_r && !nmi_take_r) // [RQ1]
        else $error("Interrupt beat reset");
    AST_WDT_ENTER: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && !pin_low && wif.overflow && !wif.reset_flag)
        |=> state_r == RXS_ST_RESET && wif.reset_flag) // [RQ10]
        else $error("Watchdog overflow did not reset");
    AST_WDT_LEAVE: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && !pin_low && wif.overflow && wif.reset_flag && state_r == RXS_ST_RESET)
        |=> state_r == RXS_ST_INIT) // [RQ11]
        else $error("Second overflow did not start handling");

    COV_PIN_RESET: cover property (@(posedge clk) state_r == RXS_ST_VEC_HI ##1 state_r == RXS_ST_FIRST);
    COV_WDT_RESET: cover property (@(posedge clk) wdt_rst_r ##1 state_r == RXS_ST_INIT);
    COV_IRQ: cover property (@(posedge clk) irq_take_r);
    COV_NMI: cover property (@(posedge clk) nmi_take_r);
endmodule : rxs_sequencer

// >>> rxs_reset_src.sv
/*
 * Board reset source model for the active-low reset pin.
 * Assumes the bench clock; the pin changes at falling edges.
 */
module rxs_reset_src (
    // Clock
    input  wire logic clk,
    // Reset pin
    output logic      rst_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MIN_LOW = 10;

    // Low from power-up until the clock has settled
    initial rst_n = 1'b0;

    task automatic drive_low;
        @(negedge clk);
        rst_n = 1'b0;
    endtask : drive_low

    task automatic release_after(input int cycles);
        int n;
        n = (cycles < MIN_LOW) ? MIN_LOW : cycles;
        repeat (n) @(negedge clk);
        rst_n = 1'b1;
    endtask : release_after
endmodule : rxs_reset_src

// >>> rxs_sequencer_test.sv
/*
 * Self-checking bench for the reset and exception-entry sequencer.
 * Assumes the design files and the board reset source model.
 */
`include "rxs_map.svh"
module rxs_sequencer_test;
    import rxs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, sys_rst, clk_en, pin_n, wd_en, insn_boundary;
    logic        irq_req, nmi_req, cpu_mask_clear, mem_rd, halt, periph_init;
    logic        cpu_start, irq_mask_bit, irq_take, nmi_take, wd_flag, start_q;
    logic [15:0] mem_addr, pc_load, vec;
    logic [7:0]  mem_rdata;
    logic [19:0] exp_q[$];
    int          err_count, checks;

    rxs_reset_src src (.clk(clk), .rst_n(pin_n));

    rxs_sequencer DUT (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .external_reset_input_n(pin_n),
        .watchdog_run_enable(wd_en), .insn_boundary(insn_boundary), .irq_req(irq_req),
        .nmi_req(nmi_req), .cpu_mask_clear(cpu_mask_clear), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .halt(halt), .periph_init(periph_init),
        .cpu_start(cpu_start), .pc_load(pc_load), .irq_mask_bit(irq_mask_bit),
        .irq_take(irq_take), .nmi_take(nmi_take), .watchdog_reset_flag(wd_flag)
    );

    always #12.5 clk = ~clk;
    // Vector word: high byte first
    assign mem_rdata = (mem_addr === `RXS_VEC_LO_ADDR) ? vec[15:8] : vec[7:0];

    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic got(input logic [3:0] kind, input logic [15:0] val);
        if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] result expected none seen %h", {kind, val});
        end else begin
            chk("result", exp_q.pop_front(), {kind, val});
        end
    endtask : got

    task automatic expect_boot;
        vec = 16'($urandom);
        exp_q.push_back({4'h1, `RXS_VEC_LO_ADDR});
        exp_q.push_back({4'h1, `RXS_VEC_HI_ADDR});
        exp_q.push_back({4'h2, vec});
    endtask : expect_boot

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic boundary;
        step(1);
        insn_boundary = 1'b1;
        step(1);
        insn_boundary = 1'b0;
    endtask : boundary

    task automatic wait_start(input int lim);
        for (int i = 0; i < lim && cpu_start !== 1'b1; i++) step(1);
        chk("cpu_start", 20'h1, {19'h0, cpu_start});
    endtask : wait_start

    task automatic conclude;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Result watcher: vector reads, PC load, interrupt takes; mid-cycle sampling
    always @(negedge clk) begin
        if (sys_rst === 1'b0) begin
            if (mem_rd === 1'b1) got(4'h1, mem_addr);
            if (cpu_start === 1'b1 && start_q !== 1'b1) got(4'h2, pc_load);
            if (irq_take === 1'b1) got(4'h3, 16'h0);
            if (nmi_take === 1'b1) got(4'h4, 16'h0);
        end
        start_q = cpu_start;
    end

    initial begin
        #(3000 * 25);
        err_count++;
        $display("[ERR] run expected finish seen timeout");
        conclude();
    end

    initial begin
        int i;
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        {wd_en, insn_boundary, irq_req, nmi_req, cpu_mask_clear, start_q} = '0;
        vec = 16'h0;
        err_count = 0;
        checks = 0;
        void'($urandom(32'h313a));
        step(2);
        sys_rst = 1'b0;
        expect_boot();
        chk("halt", 20'h1, {19'h0, halt});
        chk("periph_init", 20'h1, {19'h0, periph_init});
        src.release_after(12);
        wait_start(40);
        chk("irq_mask_bit", 20'h1, {19'h0, irq_mask_bit});
        // Requests in the first instruction and between boundaries are refused
        nmi_req = 1'b1;
        irq_req = 1'b1;
        step(3);
        boundary();
        step(3);
        exp_q.push_back({4'h4, 16'h0});
        boundary();
        step(1);
        nmi_req = 1'b0;
        boundary();
        chk("irq_mask_bit", 20'h1, {19'h0, irq_mask_bit});
        // Boundary in run state with mask set: request refused
        boundary();
        step(2);
        cpu_mask_clear = 1'b1;
        step(1);
        cpu_mask_clear = 1'b0;
        exp_q.push_back({4'h3, 16'h0});
        boundary();
        step(1);
        irq_req = 1'b0;
        step(2);
        // Pin drop beside pending requests
        src.drive_low();
        {insn_boundary, nmi_req, irq_req} = 3'h7;
        #1 chk("halt", 20'h1, {19'h0, halt});
        step(4);
        {insn_boundary, nmi_req, irq_req} = 3'h0;
        expect_boot();
        src.release_after(10);
        wait_start(40);
        boundary();
        // Clock enable low freezes the mask against a clear
        clk_en = 1'b0;
        cpu_mask_clear = 1'b1;
        step(3);
        chk("irq_mask_bit", 20'h1, {19'h0, irq_mask_bit});
        {clk_en, cpu_mask_clear} = 2'h2;
        // Watchdog idle, then two overflows
        step(300);
        chk("watchdog_reset_flag", 20'h0, {19'h0, wd_flag});
        wd_en = 1'b1;
        for (i = 0; i < 300 && wd_flag !== 1'b1; i++) step(1);
        chk("watchdog_reset_flag", 20'h1, {19'h0, wd_flag});
        step(2);
        chk("halt", 20'h1, {19'h0, halt});
        expect_boot();
        wait_start(400);
        wd_en = 1'b0;
        chk("watchdog_reset_flag", 20'h0, {19'h0, wd_flag});
        step(4);
        chk("pending", 20'h0, 20'(exp_q.size()));
        conclude();
    end
endmodule : rxs_sequencer_test
